// ==== irq_host.sv ====
// Purpose: host on the register port
// Assumes: one-cycle strobes
// Notes: write data inverted once released
`timescale 1ns/1ns
`default_nettype none
module irq_host (
  input wire logic clk,
  output logic wr = 0, rd = 0,
  output logic [7:0] addr = 8'h00, wdata = 8'h00,
  input wire logic [7:0] rdata
);
  task put(input logic [7:0] a, v);
    @(posedge clk) {wr, addr, wdata} <= {1'b1, a, v};
    @(posedge clk) {wr, wdata} <= {1'b0, ~v};
  endtask
  task get(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk) {rd, addr} <= {1'b1, a};
    @(posedge clk) rd <= 0;
    @(negedge clk) v = rdata;
  endtask
endmodule // irq_host
`default_nettype wire

// ==== irq_route_trim.v ====
// Purpose: interrupt enable, pin routing and user offset trim
// Assumes: register port decoded by the serial front end, same clock
// Notes: event flags come from blocks on core_clk_i, not synchronised
// Contract
// - temperature threshold enable at bit 2, resets 0, gates that source
// - pressure change enable at bit 1, resets 0, gates that source
// - temperature change enable at bit 0, resets 0, gates that source
// - routing register holds one pin-select bit per event source
// - routing bit 0 sends source to second pin, 1 to first
// - all routing bits reset to 0; bit 7..0 source order fixed
// - each pin is OR of all enabled sources routed to it
// - signed trims offset temperature, altitude and pressure results
// - pressure trim 8-bit signed, 4 Pa per LSB
// - temperature trim 8-bit signed, 0.0625 degC per LSB
// - altitude trim 8-bit signed, whole meters, added to altitude
// - trim registers fully read/write, reset to zero
// - enable bit gates each source flag before routing
`timescale 1ns/1ns
`default_nettype none
`include "irq_trim_defines.vh"
module irq_route_trim #(
  parameter P_WIDTH = 20,
  parameter T_WIDTH = 12,
  parameter H_WIDTH = 20
) (
  // clock and reset
  input wire core_clk_i,
  input wire rst_i,
  // register port
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  // event flags, bit 7 data-ready down to bit 0 temperature change
  input wire [7:0] event_flags_i,
  // raw results, pressure in 1 Pa units, trim LSB/4
  input wire [P_WIDTH-1:0] pressure_raw_i,
  input wire [T_WIDTH-1:0] temp_raw_i,
  input wire [H_WIDTH-1:0] altitude_raw_i,
  // interrupt pins, active high, push-pull
  output reg first_interrupt_pin_o,
  output reg second_interrupt_pin_o,
  // trimmed results
  output wire [P_WIDTH-1:0] pressure_trimmed_o,
  output wire [T_WIDTH-1:0] temp_trimmed_o,
  output wire [H_WIDTH-1:0] altitude_trimmed_o
);
  reg [7:0] irq_enable;
  reg [7:0] interrupt_pin_routing;
  reg [7:0] pressure_offset_trim;
  reg [7:0] temperature_offset_trim;
  reg [7:0] altitude_offset_trim;
  reg [7:0] next_rdata;
  // per-register write strobes
  wire wr_enable;
  wire wr_routing;
  wire wr_pressure_trim;
  wire wr_temp_trim;
  wire wr_altitude_trim;
  // named enable bits of the last three sources
  wire temp_threshold_irq_enable;
  wire pressure_change_irq_enable;
  wire temp_change_irq_enable;
  wire [7:0] enable_vec;
  // named pin-select bits, 1 first pin, 0 second pin
  wire data_ready_route_sel;
  wire fifo_route_sel;
  wire pressure_window_route_sel;
  wire temp_window_route_sel;
  wire pressure_threshold_route_sel;
  wire temp_threshold_route_sel;
  wire pressure_change_route_sel;
  wire temp_change_route_sel;
  wire [7:0] route_vec;
  wire [7:0] gated;
  wire [7:0] to_first;
  wire [7:0] to_second;
  wire next_first_pin;
  wire next_second_pin;

  // writes to unmapped addresses match no strobe and are dropped
  assign wr_enable = reg_wr_i & (reg_addr_i == `ADDR_IRQ_ENABLE);
  assign wr_routing = reg_wr_i & (reg_addr_i == `ADDR_PIN_ROUTING);
  assign wr_pressure_trim = reg_wr_i & (reg_addr_i == `ADDR_PRESSURE_TRIM);
  assign wr_temp_trim = reg_wr_i & (reg_addr_i == `ADDR_TEMP_TRIM);
  assign wr_altitude_trim = reg_wr_i & (reg_addr_i == `ADDR_ALTITUDE_TRIM);

  assign temp_threshold_irq_enable = irq_enable[`BIT_TEMP_THRESHOLD];
  assign pressure_change_irq_enable = irq_enable[`BIT_PRESSURE_CHANGE];
  assign temp_change_irq_enable = irq_enable[`BIT_TEMP_CHANGE];
  assign enable_vec = {irq_enable[7:3], temp_threshold_irq_enable,
    pressure_change_irq_enable, temp_change_irq_enable};

  assign data_ready_route_sel = interrupt_pin_routing[7];
  assign fifo_route_sel = interrupt_pin_routing[6];
  assign pressure_window_route_sel = interrupt_pin_routing[5];
  assign temp_window_route_sel = interrupt_pin_routing[4];
  assign pressure_threshold_route_sel = interrupt_pin_routing[3];
  assign temp_threshold_route_sel = interrupt_pin_routing[2];
  assign pressure_change_route_sel = interrupt_pin_routing[1];
  assign temp_change_route_sel = interrupt_pin_routing[0];
  assign route_vec = {data_ready_route_sel, fifo_route_sel,
    pressure_window_route_sel, temp_window_route_sel,
    pressure_threshold_route_sel, temp_threshold_route_sel,
    pressure_change_route_sel, temp_change_route_sel};

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_enable <= `RESET_BYTE;
    end else if (wr_enable) begin
      irq_enable <= reg_wdata_i;
    end
  end

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      interrupt_pin_routing <= `RESET_BYTE;
    end else if (wr_routing) begin
      interrupt_pin_routing <= reg_wdata_i;
    end
  end

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pressure_offset_trim <= `RESET_BYTE;
    end else if (wr_pressure_trim) begin
      pressure_offset_trim <= reg_wdata_i;
    end
  end

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      temperature_offset_trim <= `RESET_BYTE;
    end else if (wr_temp_trim) begin
      temperature_offset_trim <= reg_wdata_i;
    end
  end

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      altitude_offset_trim <= `RESET_BYTE;
    end else if (wr_altitude_trim) begin
      altitude_offset_trim <= reg_wdata_i;
    end
  end

  // unmapped reads return zero
  always @* begin
    case (reg_addr_i)
      `ADDR_IRQ_ENABLE: next_rdata = irq_enable;
      `ADDR_PIN_ROUTING: next_rdata = interrupt_pin_routing;
      `ADDR_PRESSURE_TRIM: next_rdata = pressure_offset_trim;
      `ADDR_TEMP_TRIM: next_rdata = temperature_offset_trim;
      `ADDR_ALTITUDE_TRIM: next_rdata = altitude_offset_trim;
      default: next_rdata = 8'h00;
    endcase
  end

  // read data held until the next read so the serial side can shift it
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end
  end

  genvar i;
  generate
    for (i = 0; i < `NUM_SOURCES; i = i + 1) begin : g_src
      assign gated[i] = event_flags_i[i] & enable_vec[i];
      assign to_first[i] = gated[i] & route_vec[i];
      assign to_second[i] = gated[i] & ~route_vec[i];
    end
  endgenerate

  // several sources may share a pin; host sorts them out
  assign next_first_pin = |to_first;
  assign next_second_pin = |to_second;

  // one register stage; a routing change moves the source next cycle
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      first_interrupt_pin_o <= 1'b0;
      second_interrupt_pin_o <= 1'b0;
    end else begin
      first_interrupt_pin_o <= next_first_pin;
      second_interrupt_pin_o <= next_second_pin;
    end
  end

  // pressure LSB is 1 Pa, so trim shifts up by two
  trim_adder #(.WIDTH(P_WIDTH), .SHIFT(`PRESSURE_TRIM_SHIFT)) u_p (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .raw_i(pressure_raw_i),
    .trim_i(pressure_offset_trim),
    .trimmed_o(pressure_trimmed_o)
  );

  trim_adder #(.WIDTH(T_WIDTH), .SHIFT(`TEMP_TRIM_SHIFT)) u_t (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .raw_i(temp_raw_i),
    .trim_i(temperature_offset_trim),
    .trimmed_o(temp_trimmed_o)
  );

  trim_adder #(.WIDTH(H_WIDTH), .SHIFT(`ALTITUDE_TRIM_SHIFT)) u_h (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .raw_i(altitude_raw_i),
    .trim_i(altitude_offset_trim),
    .trimmed_o(altitude_trimmed_o)
  );
endmodule // irq_route_trim
`default_nettype wire

// ==== irq_route_trim_asserts.sv ====
// Purpose: pin and register port checks
// Assumes: one clock
// Notes: shadow bytes avoid peeking inside
`timescale 1ns/1ns
`default_nettype none
module irq_route_trim_asserts (
  input wire logic core_clk_i, rst_i, reg_wr_i, reg_rd_i,
  input wire logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, event_flags_i,
  input wire logic first_interrupt_pin_o, second_interrupt_pin_o
);
  logic [7:0] en, rt;
  always @(posedge core_clk_i or posedge rst_i)
    if (rst_i) {en, rt} <= 16'h0000;
    else if (reg_wr_i && reg_addr_i == 8'h29) en <= reg_wdata_i;
    else if (reg_wr_i && reg_addr_i == 8'h2A) rt <= reg_wdata_i;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_wr; reg_wr_i && reg_addr_i inside {[8'h29:8'h2D]}; endsequence
  property p_pin1; first_interrupt_pin_o ==
    |($past(event_flags_i) & $past(en) & $past(rt)); endproperty
  a_pin1: assert property (p_pin1) else $error("pin1");
  property p_pin2; second_interrupt_pin_o ==
    |($past(event_flags_i) & $past(en) & ~$past(rt)); endproperty
  a_pin2: assert property (p_pin2) else $error("pin2");
  property p_gate; (event_flags_i & en) == 8'h00 |=>
    !first_interrupt_pin_o && !second_interrupt_pin_o; endproperty
  a_gate: assert property (p_gate) else $error("gate");
  property p_unmap; reg_rd_i && reg_addr_i > 8'h2D |=> reg_rdata_o == 0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmap");
  property p_hold; !reg_rd_i |=> $stable(reg_rdata_o); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_en; reg_rd_i && reg_addr_i == 8'h29 |=> reg_rdata_o == $past(en);
  endproperty
  a_en: assert property (p_en) else $error("enable");
  property p_rt; reg_rd_i && reg_addr_i == 8'h2A |=> reg_rdata_o == $past(rt);
  endproperty
  a_rt: assert property (p_rt) else $error("route");
  property p_rw; s_wr ##1 !reg_wr_i ##1 reg_rd_i && $stable(reg_addr_i)
    |=> reg_rdata_o == $past(reg_wdata_i, 3); endproperty
  a_rw: assert property (p_rw) else $error("readback");
endmodule // irq_route_trim_asserts
`default_nettype wire

// ==== irq_trim_defines.vh ====
// Purpose: constants for interrupt routing and offset trim block
// Assumes: byte-wide register port, 8-bit register addresses
// Notes: definitions only
`ifndef IRQ_TRIM_DEFINES_VH
`define IRQ_TRIM_DEFINES_VH
`define ADDR_IRQ_ENABLE 8'h29
`define ADDR_PIN_ROUTING 8'h2A
`define ADDR_PRESSURE_TRIM 8'h2B
`define ADDR_TEMP_TRIM 8'h2C
`define ADDR_ALTITUDE_TRIM 8'h2D
`define RESET_BYTE 8'h00
`define NUM_SOURCES 8
`define BIT_TEMP_THRESHOLD 2
`define BIT_PRESSURE_CHANGE 1
`define BIT_TEMP_CHANGE 0
`define PRESSURE_TRIM_SHIFT 2
`define TEMP_TRIM_SHIFT 0
`define ALTITUDE_TRIM_SHIFT 0
`endif

// ==== tb.sv ====
// Purpose: bench for routing and trims
// Assumes: host model drives the port
// Notes: one value for the pressure trim, two each for temperature and altitude
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic core_clk_i = 0, rst_i = 1, reg_wr_i, reg_rd_i, p1, p2;
  logic [7:0] event_flags_i = 8'h00, reg_addr_i, reg_wdata_i, reg_rdata_o, d;
  logic [19:0] pressure_raw_i = 20'h00064, pt, ht;
  logic [19:0] altitude_raw_i = 20'h00010;
  logic [11:0] temp_raw_i = 12'h100, tt;
  int n_mismatch = 0, checks = 0;
  // enable, route, flags, expected {first, second}
  logic [31:0] rows [7] = '{32'h04000401, 32'h0000FF00, 32'h02020202,
    32'h01000101, 32'hFF0FFF03, 32'hFFF00F01, 32'hFB040400};
  always #25 core_clk_i = ~core_clk_i;
  irq_host h (.clk(core_clk_i), .wr(reg_wr_i), .rd(reg_rd_i),
    .addr(reg_addr_i), .wdata(reg_wdata_i), .rdata(reg_rdata_o));
  irq_route_trim i_dut (.core_clk_i, .rst_i, .reg_wr_i, .reg_rd_i,
    .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .event_flags_i,
    .pressure_raw_i, .temp_raw_i, .altitude_raw_i,
    .first_interrupt_pin_o(p1), .second_interrupt_pin_o(p2),
    .pressure_trimmed_o(pt), .temp_trimmed_o(tt), .altitude_trimmed_o(ht));
  task chk(input logic [31:0] g, e);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t %h %h", $time, g, e);
    end
  endtask
  task rc(input logic [7:0] a, e);
    h.get(a, d);
    chk(d, e);
  endtask
  task results;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #200000 n_mismatch++;
    results;
  end
  initial begin
    repeat (10) @(posedge core_clk_i);
    rst_i <= 0;
    foreach (rows[i]) begin
      h.put(8'h29, rows[i][31:24]);
      h.put(8'h2A, rows[i][23:16]);
      @(posedge core_clk_i) event_flags_i <= rows[i][15:8];
      repeat (2) @(posedge core_clk_i);
      #1 chk({p1, p2}, rows[i][1:0]);
    end
    rc(8'h29, 8'hFB);
    h.put(8'h2B, 8'hFF);
    h.put(8'h2C, 8'h80);
    h.put(8'h2D, 8'h7F);
    repeat (2) @(posedge core_clk_i);
    #1 chk(pt, 20'h00060);
    chk(tt, 12'h080);
    chk(ht, 20'h0008F);
    rc(8'h2B, 8'hFF);
    rc(8'h30, 8'h00);
    h.put(8'h2C, 8'h5A);
    rc(8'h2C, 8'h5A);
    h.put(8'h2D, 8'h81);
    rc(8'h2D, 8'h81);
    @(posedge core_clk_i) rst_i <= 1;
    @(posedge core_clk_i) rst_i <= 0;
    rc(8'h2A, 8'h00);
    rc(8'h29, 8'h00);
    rc(8'h2C, 8'h00);
    rc(8'h2D, 8'h00);
    chk(pt, pressure_raw_i);
    chk(tt, temp_raw_i);
    chk(ht, altitude_raw_i);
    results;
  end
endmodule // tb
bind irq_route_trim irq_route_trim_asserts i_chk (.core_clk_i, .rst_i,
  .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
  .event_flags_i, .first_interrupt_pin_o, .second_interrupt_pin_o);
`default_nettype wire

// ==== trim_adder.v ====
// Purpose: add a signed 8-bit trim, scaled by a shift, to a measurement
// Assumes: measurement and trim share the trim's LSB after shifting
// Notes: registered output, wraps on overflow
`timescale 1ns/1ns
`default_nettype none
module trim_adder #(
  parameter WIDTH = 20,
  parameter SHIFT = 0
) (
  // clock and reset
  input wire core_clk_i,
  input wire rst_i,
  // operands
  input wire [WIDTH-1:0] raw_i,
  input wire [7:0] trim_i,
  // result
  output reg [WIDTH-1:0] trimmed_o
);
  wire [WIDTH-1:0] trim_ext;
  assign trim_ext = {{(WIDTH-8){trim_i[7]}}, trim_i} << SHIFT;
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      trimmed_o <= {WIDTH{1'b0}};
    end else begin
      trimmed_o <= raw_i + trim_ext;
    end
  end
endmodule // trim_adder
`default_nettype wire
